/* hdl/frc_consts.svh */
/*
 * Constants for the range CRC check host: command codes, pin addresses, sequence lengths, bus timing.
 * Assumes a 50 MHz sys_clk; timing counts are derived from times in nanoseconds.
 */
`ifndef FRC_CONSTS_SVH
`define FRC_CONSTS_SVH

`define FRC_CLK_NS 20
// Unlock cycles
`define FRC_UNLOCK1_DATA 16'h00AA
`define FRC_UNLOCK2_DATA 16'h0055
`define FRC_UNLOCK1_WADDR 32'h0000_0555
`define FRC_UNLOCK2_WADDR 32'h0000_02AA
`define FRC_UNLOCK1_BADDR 32'h0000_0AAA
`define FRC_UNLOCK2_BADDR 32'h0000_0555
// Command words
`define FRC_EXT_FUNC_CMD 16'h00EB
`define FRC_CRC_SUBOP 16'h0027
`define FRC_COUNT_WORD 16'h000A
`define FRC_COUNT_BYTE 16'h0015
`define FRC_OPTION_RANGE 16'hFFFE
`define FRC_RESERVED_WORD 16'h0000
`define FRC_CONFIRM_CMD 16'h0029
// Step numbering of the write sequence
`define FRC_STEP_UNLOCK1 6'h00
`define FRC_STEP_UNLOCK2 6'h01
`define FRC_STEP_EXT 6'h02
`define FRC_STEP_SUBOP 6'h03
`define FRC_STEP_COUNT 6'h04
`define FRC_STEP_PARAM0 6'h05
`define FRC_LAST_STEP_WORD 6'h10
`define FRC_LAST_STEP_BYTE 6'h1B
// Parameter entry positions
`define FRC_ENT_OPTION 4'h0
`define FRC_ENT_CRC0 4'h1
`define FRC_ENT_CRC1 4'h2
`define FRC_ENT_CRC2 4'h3
`define FRC_ENT_CRC3 4'h4
`define FRC_ENT_START_LO 4'h5
`define FRC_ENT_START_HI 4'h6
`define FRC_ENT_STOP_LO 4'h8
`define FRC_ENT_STOP_HI 4'h9
// Polling status bits; DQ15 carries the byte address lsb in byte mode
`define FRC_DQ_ERROR 5
`define FRC_DQ_TOGGLE 6
`define FRC_DQ_ALINE 15
// Bus timing, times in ns; least times round up
`define FRC_WE_LOW_NS 50
`define FRC_WE_HIGH_NS 40
`define FRC_READ_NS 110
`define FRC_WE_LOW_CYC (8'((`FRC_WE_LOW_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS))
`define FRC_WE_HIGH_CYC (8'((`FRC_WE_HIGH_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS))
// Read strobe also covers the two-stage input synchroniser
`define FRC_READ_CYC (8'((`FRC_READ_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS) + 8'h02)

`endif

/* hdl/frc_pkg.sv */
/*
 * Types for the range CRC check host.
 * Assumes frc_consts.svh supplies all numeric constants.
 */
package frc_pkg;
  typedef enum logic [6:0] {
    FRC_IDLE = 7'b0000001,
    FRC_SETUP = 7'b0000010,
    FRC_WPULSE = 7'b0000100,
    FRC_WREC = 7'b0001000,
    FRC_RPULSE = 7'b0010000,
    FRC_RGAP = 7'b0100000,
    FRC_FINISH = 7'b1000000
  } frc_state_e;
  typedef logic [15:0] frc_word_t;
  typedef logic [31:0] frc_baddr_t;
  typedef logic [63:0] frc_crc_t;
endpackage

/* hdl/frc_range_check_host.sv */
/*
 * Host controller that asks a parallel NOR flash to run its range CRC-64 check and polls for the verdict.
 * Assumes the flash pins are asynchronous to sys_clk; the board resolves the data bus from the enables.
 */
//
// Overview of operation
// - Send unlocks, EBh then 27h at zero.
// - Send count 000Ah word or 15h byte.
// - Send option FFFEh, or FEh, FFh bytes.
// - Send expected CRC at offsets one to four.
// - Send start byte address at offsets five, six.
// - Send stop at eight, nine; zeros at seven, ten.
// - Confirm with 0029h, then poll until ready or an error shows.
`timescale 1ns/10ps
`include "frc_consts.svh"

module frc_range_check_host #(
  parameter int ADDR_W = 25
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // User request
  input wire logic startReq,
  input wire logic byteMode,
  input wire frc_pkg::frc_crc_t expectedCrc,
  input wire frc_pkg::frc_baddr_t rangeStart,
  input wire frc_pkg::frc_baddr_t rangeStop,
  // User result
  output logic busy,
  output logic donePulse,
  output logic checkPassed,
  output logic checkFailed,
  output logic rangeRefused,
  // Flash pins
  output logic [ADDR_W-1:0] flashAddr,
  output logic chipEnable_n,
  output logic writeEnable_n,
  output logic outputEnable_n,
  output logic byteSelect_n,
  input wire logic [15:0] dqIn,
  output logic [15:0] dqOut,
  output logic dqOe_n
);
  import frc_pkg::*;

  frc_state_e state_reg, state_next;
  logic [1:0] rstSync_reg;
  logic rst_n;
  logic [15:0] dqMeta_reg, dqSync_reg;
  logic [5:0] step_reg;
  logic [7:0] timer_reg;
  logic modeByte_reg;
  frc_crc_t crc_reg;
  frc_baddr_t startAddr_reg, stopAddr_reg;
  logic polling_reg, havePrev_reg, prevToggle_reg, prevErr_reg;
  logic timerDone, lastStep, toggleStopped, failSeen;
  frc_baddr_t busAddr;
  frc_word_t busData;

  // Parameter entry k of the range request, in word-mode order
  function automatic frc_word_t paramEntry(input logic [3:0] k);
    case (k)
      `FRC_ENT_OPTION: paramEntry = `FRC_OPTION_RANGE;
      `FRC_ENT_CRC0: paramEntry = crc_reg[15:0];
      `FRC_ENT_CRC1: paramEntry = crc_reg[31:16];
      `FRC_ENT_CRC2: paramEntry = crc_reg[47:32];
      `FRC_ENT_CRC3: paramEntry = crc_reg[63:48];
      `FRC_ENT_START_LO: paramEntry = startAddr_reg[15:0];
      `FRC_ENT_START_HI: paramEntry = startAddr_reg[31:16];
      `FRC_ENT_STOP_LO: paramEntry = stopAddr_reg[15:0];
      `FRC_ENT_STOP_HI: paramEntry = stopAddr_reg[31:16];
      default: paramEntry = `FRC_RESERVED_WORD;
    endcase
  endfunction

  // Address (word address in word mode, byte address in byte mode) and data of one write step; byte mode splits each entry low byte first
  always_comb begin
    logic [5:0] off;
    frc_word_t ent;
    off = step_reg - `FRC_STEP_PARAM0;
    ent = paramEntry(modeByte_reg ? off[4:1] : off[3:0]);
    busAddr = 32'h0000_0000;
    busData = `FRC_CONFIRM_CMD;
    case (step_reg)
      `FRC_STEP_UNLOCK1: begin
        busAddr = modeByte_reg ? `FRC_UNLOCK1_BADDR : `FRC_UNLOCK1_WADDR;
        busData = `FRC_UNLOCK1_DATA;
      end
      `FRC_STEP_UNLOCK2: begin
        busAddr = modeByte_reg ? `FRC_UNLOCK2_BADDR : `FRC_UNLOCK2_WADDR;
        busData = `FRC_UNLOCK2_DATA;
      end
      `FRC_STEP_EXT: busData = `FRC_EXT_FUNC_CMD;
      `FRC_STEP_SUBOP: busData = `FRC_CRC_SUBOP;
      `FRC_STEP_COUNT: busData = modeByte_reg ? `FRC_COUNT_BYTE : `FRC_COUNT_WORD;
      default: begin
        if (!lastStep) begin
          busAddr = {26'h0000000, off};
          if (modeByte_reg) begin
            busData = off[0] ? {8'h00, ent[15:8]} : {8'h00, ent[7:0]};
          end else begin
            busData = ent;
          end
        end
      end
    endcase
  end

  assign lastStep = step_reg == (modeByte_reg ? `FRC_LAST_STEP_BYTE : `FRC_LAST_STEP_WORD);
  assign timerDone = timer_reg == 8'h00;
  assign toggleStopped = havePrev_reg && (prevToggle_reg == dqSync_reg[`FRC_DQ_TOGGLE]);
  assign failSeen = havePrev_reg && prevErr_reg && !toggleStopped;

  // Reset release through two stages
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_reg <= 2'b00;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rst_n = rstSync_reg[1];

  // Data pins come from the flash's own timing domain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqMeta_reg <= 16'h0000;
      dqSync_reg <= 16'h0000;
    end else begin
      dqMeta_reg <= dqIn;
      dqSync_reg <= dqMeta_reg;
    end
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FRC_IDLE: begin
        if (startReq) begin
          // The flash would silently ignore an empty range, so it is refused here instead
          state_next = (rangeStop > rangeStart) ? FRC_SETUP : FRC_FINISH;
        end
      end
      FRC_SETUP: state_next = FRC_WPULSE;
      FRC_WPULSE: if (timerDone) state_next = FRC_WREC;
      FRC_WREC: if (timerDone) state_next = lastStep ? FRC_RPULSE : FRC_SETUP;
      FRC_RPULSE: begin
        if (timerDone) begin
          state_next = (toggleStopped || failSeen) ? FRC_FINISH : FRC_RGAP;
        end
      end
      FRC_RGAP: if (timerDone) state_next = FRC_RPULSE;
      FRC_FINISH: state_next = FRC_IDLE;
      default: state_next = FRC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FRC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Phase timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= 8'h00;
    end else if (state_next != state_reg) begin
      case (state_next)
        FRC_WPULSE: timer_reg <= `FRC_WE_LOW_CYC - 8'h01;
        FRC_WREC: timer_reg <= `FRC_WE_HIGH_CYC - 8'h01;
        FRC_RPULSE: timer_reg <= `FRC_READ_CYC - 8'h01;
        FRC_RGAP: timer_reg <= `FRC_WE_HIGH_CYC - 8'h01;
        default: timer_reg <= 8'h00;
      endcase
    end else if (!timerDone) begin
      timer_reg <= timer_reg - 8'h01;
    end
  end

  // Request capture and step counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeByte_reg <= 1'b0;
      crc_reg <= 64'h0000_0000_0000_0000;
      startAddr_reg <= 32'h0000_0000;
      stopAddr_reg <= 32'h0000_0000;
      step_reg <= 6'h00;
    end else if (state_reg == FRC_IDLE) begin
      modeByte_reg <= byteMode;
      crc_reg <= expectedCrc;
      startAddr_reg <= rangeStart;
      stopAddr_reg <= rangeStop;
      step_reg <= `FRC_STEP_UNLOCK1;
    end else if (state_reg == FRC_WREC && timerDone && !lastStep) begin
      step_reg <= step_reg + 6'h01;
    end
  end

  // Polling history: toggle bit and error bit of the previous status read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      havePrev_reg <= 1'b0;
      prevToggle_reg <= 1'b0;
      prevErr_reg <= 1'b0;
    end else if (state_reg == FRC_IDLE) begin
      havePrev_reg <= 1'b0;
    end else if (state_reg == FRC_RPULSE && timerDone) begin
      havePrev_reg <= 1'b1;
      prevToggle_reg <= dqSync_reg[`FRC_DQ_TOGGLE];
      prevErr_reg <= dqSync_reg[`FRC_DQ_ERROR];
    end
  end

  // Results
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      donePulse <= 1'b0;
      checkPassed <= 1'b0;
      checkFailed <= 1'b0;
      rangeRefused <= 1'b0;
      polling_reg <= 1'b0;
    end else begin
      donePulse <= state_reg == FRC_FINISH;
      polling_reg <= state_reg == FRC_RPULSE || state_reg == FRC_RGAP;
      if (state_reg == FRC_IDLE && startReq) begin
        checkPassed <= 1'b0;
        checkFailed <= 1'b0;
        rangeRefused <= !(rangeStop > rangeStart);
      end else if (state_reg == FRC_RPULSE && timerDone && toggleStopped) begin
        // Device went ready; a set error bit in the last two reads means mismatch
        checkFailed <= prevErr_reg || dqSync_reg[`FRC_DQ_ERROR];
        checkPassed <= !(prevErr_reg || dqSync_reg[`FRC_DQ_ERROR]);
      end else if (state_reg == FRC_RPULSE && timerDone && failSeen) begin
        checkFailed <= 1'b1;
      end
    end
  end

  // Pin drive; in byte mode the top data line carries the byte address lsb
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flashAddr <= '0;
      dqOut <= 16'h0000;
      byteSelect_n <= 1'b1;
    end else begin
      byteSelect_n <= !modeByte_reg;
      if (state_reg == FRC_SETUP) begin
        if (modeByte_reg) begin
          flashAddr <= busAddr[ADDR_W:1];
          dqOut <= {busAddr[0], busData[14:0]};
        end else begin
          flashAddr <= busAddr[ADDR_W-1:0];
          dqOut <= busData;
        end
      end else if (state_reg == FRC_WREC && lastStep) begin
        flashAddr <= '0;
        dqOut <= 16'h0000;
      end
    end
  end

  assign busy = state_reg != FRC_IDLE;
  assign chipEnable_n = !(state_reg == FRC_SETUP || state_reg == FRC_WPULSE || state_reg == FRC_WREC ||
    state_reg == FRC_RPULSE);
  assign writeEnable_n = state_reg != FRC_WPULSE;
  assign outputEnable_n = state_reg != FRC_RPULSE;
  // The top line is released with all the others while reading, in byte mode too
  assign dqOe_n = !(state_reg == FRC_SETUP || state_reg == FRC_WPULSE || state_reg == FRC_WREC) || polling_reg;
endmodule

/* verif/frc_flash_model.sv */
/* Behavioural flash answering the range CRC sequence.
   Clockless: acts on strobe edges; array byte at A is A[7:0]^5Ah. */
`timescale 1ns/10ps
module frc_flash_model (
  // Bus pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic byte_n,
  input wire logic [24:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  // Busy polls before ready, accepted checks
  input wire logic [3:0] slowReads,
  output int accepted = 0
);
  localparam logic [63:0] POLY = 64'h42F0_E1EB_A9EA_3693;
  localparam logic [7:0] CMD [5] = '{8'hAA, 8'h55, 8'hEB, 8'h27, 8'h0A};
  localparam logic [11:0] WAD [5] = '{12'h555, 12'h2AA, 12'h000, 12'h000, 12'h000};
  localparam logic [11:0] BAD [5] = '{12'hAAA, 12'h555, 12'h000, 12'h000, 12'h000};
  logic [15:0] p [0:10];
  logic [15:0] st = 16'h0000;
  logic [31:0] ba, s, e;
  logic [15:0] dv;
  logic [7:0] ex;
  logic err = 1'b0;
  int step = 0;
  int left = 0;
  function automatic logic [63:0] crc_range(input logic [31:0] sa, input logic [31:0] ea);
    logic [63:0] c;
    logic [7:0] b;
    c = '0;
    for (logic [31:0] a = sa; a <= ea; a++) begin
      b = a[7:0] ^ 8'h5A;
      for (int i = 0; i < 8; i++) c = {c[62:0], 1'b0} ^ ((c[63] ^ b[i]) ? POLY : '0);
    end
    return c;
  endfunction
  always @(posedge we_n) begin
    if (!ce_n) begin
      ba = byte_n ? 32'(addr) : {6'h00, addr, din[15]};
      dv = byte_n ? din : {8'h00, din[7:0]};
      if (step < 5) begin
        ex = (!byte_n && step == 4) ? 8'h15 : CMD[step];
        // Any stray write drops back to reading the array
        step = (dv == {8'h00, ex} && ba == 32'(byte_n ? WAD[step] : BAD[step])) ? step + 1 : 0;
      end else if (step < (byte_n ? 16 : 27)) begin
        if (byte_n) p[ba] = dv;
        else p[ba >> 1][8 * ba[0] +: 8] = dv[7:0];
        step++;
      end else begin
        step = 0;
        s = {p[6], p[5]};
        e = {p[9], p[8]};
        if (ba == 0 && dv == 16'h0029 && e > s && p[0] == 16'hFFFE && p[7] == 0 && p[10] == 0) begin
          err = crc_range(s, e) != {p[4], p[3], p[2], p[1]};
          left = slowReads;
          accepted++;
        end
      end
    end
  end
  always @(negedge oe_n) begin
    // Select and read enable fall in the same step; let both settle first
    #1;
    if (!ce_n && !oe_n) begin
      if (left > 0 || err) st[6] = !st[6];
      st[5] = left == 0 && err;
      if (left > 0) left--;
    end
  end
  // Released bus shows the inverse so a stale value never looks valid
  assign dout = (!oe_n && !ce_n) ? st : ~st;
endmodule

/* verif/frc_range_check_host_chk.sv */
/* Pin and result checker for the range CRC host.
   Bound to frc_range_check_host below; sees its ports only. */
`timescale 1ns/10ps
module frc_range_check_host_chk #(
  parameter int ADDR_W = 25
) (
  // Clock, reset and request
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic startReq,
  input wire logic byteMode,
  input wire frc_pkg::frc_baddr_t rangeStart,
  input wire frc_pkg::frc_baddr_t rangeStop,
  // Result
  input wire logic busy,
  input wire logic donePulse,
  input wire logic checkPassed,
  input wire logic checkFailed,
  input wire logic rangeRefused,
  // Flash pins
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic chipEnable_n,
  input wire logic writeEnable_n,
  input wire logic outputEnable_n,
  input wire logic byteSelect_n,
  input wire logic [15:0] dqOut,
  input wire logic dqOe_n
);
  import frc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic take;
  assign take = startReq && !busy;
  sequence s_wpulse; !writeEnable_n [*3] ##1 writeEnable_n [*2]; endsequence
  sequence s_rpulse; !outputEnable_n [*8] ##1 chipEnable_n [*2]; endsequence
  // A refused range must never touch the bus
  sequence s_refused; chipEnable_n [*2] ##1 (donePulse && chipEnable_n) ##1 rangeRefused; endsequence
  property p_wpulse; $fell(writeEnable_n) |-> s_wpulse; endproperty
  a_wpulse: assert property (p_wpulse) else $error("write strobe width wrong");
  property p_wdrive; !writeEnable_n |-> !chipEnable_n && !dqOe_n && outputEnable_n; endproperty
  a_wdrive: assert property (p_wdrive) else $error("write strobe without select or drive");
  property p_rpulse; $fell(outputEnable_n) |-> s_rpulse; endproperty
  a_rpulse: assert property (p_rpulse) else $error("poll read shape wrong");
  property p_rdrive; !outputEnable_n |-> dqOe_n && !chipEnable_n; endproperty
  a_rdrive: assert property (p_rdrive) else $error("data driven during read");
  property p_unlock;
    take && rangeStop > rangeStart && !byteMode |->
      ##[1:5] ($fell(writeEnable_n) && flashAddr == ADDR_W'(12'h555) && dqOut == 16'h00AA);
  endproperty
  a_unlock: assert property (p_unlock) else $error("first unlock write wrong");
  property p_refuse; take && rangeStop <= rangeStart |-> s_refused; endproperty
  a_refuse: assert property (p_refuse) else $error("empty range not refused");
  property p_done; donePulse |=> !donePulse && $onehot({checkPassed, checkFailed, rangeRefused}); endproperty
  a_done: assert property (p_done) else $error("verdict not unique");
  property p_clear; take |=> busy ##2 !(checkPassed || checkFailed); endproperty
  a_clear: assert property (p_clear) else $error("old verdict kept");
  property p_bytehi; !writeEnable_n && !byteSelect_n |-> dqOut[14:8] == 7'h00; endproperty
  a_bytehi: assert property (p_bytehi) else $error("byte write upper lines not zero");
  property p_bsel; take && rangeStop > rangeStart |-> ##3 byteSelect_n == !$past(byteMode, 3); endproperty
  a_bsel: assert property (p_bsel) else $error("width select wrong");
endmodule

bind frc_range_check_host frc_range_check_host_chk #(.ADDR_W(ADDR_W)) chk_u (.sys_clk, .arst_n, .startReq,
  .byteMode, .rangeStart, .rangeStop, .busy, .donePulse, .checkPassed, .checkFailed, .rangeRefused,
  .flashAddr, .chipEnable_n, .writeEnable_n, .outputEnable_n, .byteSelect_n, .dqOut, .dqOe_n);

/* verif/frc_range_check_host_tb.sv */
/* Self-checking bench for the range CRC host with a behavioural flash.
   Assumes the checker file is compiled alongside for its bind. */
`timescale 1ns/10ps
module frc_range_check_host_tb;
  import frc_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic startReq = 1'b0;
  logic byteMode = 1'b0;
  frc_crc_t expectedCrc = '0;
  frc_baddr_t rangeStart = '0;
  frc_baddr_t rangeStop = '0;
  logic busy, donePulse, checkPassed, checkFailed, rangeRefused, dqOe_n;
  logic chipEnable_n, writeEnable_n, outputEnable_n, byteSelect_n;
  logic [24:0] flashAddr;
  logic [15:0] dqOut, flashDq, dqIn;
  logic [3:0] slowReads = 4'h0;
  int fail_count = 0;
  int checks_done = 0;
  int sent = 0;
  assign dqIn = !dqOe_n ? dqOut : flashDq;
  initial forever #10 sys_clk = !sys_clk;
  frc_range_check_host dut_u (.sys_clk, .arst_n, .startReq, .byteMode, .expectedCrc, .rangeStart,
    .rangeStop, .busy, .donePulse, .checkPassed, .checkFailed, .rangeRefused, .flashAddr, .chipEnable_n,
    .writeEnable_n, .outputEnable_n, .byteSelect_n, .dqIn, .dqOut, .dqOe_n);
  frc_flash_model flash_u (.ce_n(chipEnable_n), .we_n(writeEnable_n), .oe_n(outputEnable_n),
    .byte_n(byteSelect_n), .addr(flashAddr), .din(dqOut), .dout(flashDq), .slowReads, .accepted());
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // res is {passed, failed, refused}; a second request while busy must be ignored
  task automatic run(input logic bm, input frc_baddr_t s, input frc_baddr_t e, input frc_crc_t c,
      input logic [2:0] res);
    int n;
    n = 0;
    byteMode = bm;
    rangeStart = s;
    rangeStop = e;
    expectedCrc = c;
    startReq = 1'b1;
    @(negedge sys_clk);
    while (donePulse !== 1'b1 && n < 3000) begin
      startReq = (n == 4) && busy;
      @(negedge sys_clk);
      n++;
    end
    startReq = 1'b0;
    if (!res[0]) sent++;
    check(64'(n < 3000), 64'h1);
    @(negedge sys_clk);
    check({checkPassed, checkFailed, rangeRefused, 32'(flash_u.accepted)}, {res, 32'(sent)});
  endtask
  task automatic t_word;
    slowReads = 4'h3;
    run(1'b0, 32'h0000_0010, 32'h0000_003F, flash_u.crc_range(32'h10, 32'h3F), 3'b100);
    run(1'b0, 32'h0000_0010, 32'h0000_003F, ~flash_u.crc_range(32'h10, 32'h3F), 3'b010);
  endtask
  task automatic t_byte;
    slowReads = 4'h0;
    run(1'b1, 32'h0001_7FFF, 32'h0001_8010, flash_u.crc_range(32'h17FFF, 32'h18010), 3'b100);
    run(1'b1, 32'h0000_0001, 32'h0000_0002, 64'h0000_0000_0000_0001, 3'b010);
  endtask
  task automatic t_refuse;
    run(1'b0, 32'h0000_0020, 32'h0000_0020, '0, 3'b001);
    run(1'b1, 32'h0000_0021, 32'h0000_0020, '0, 3'b001);
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_word;
    t_refuse;
    t_byte;
    close_out;
  end
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule
